/* src/psq_pkg.sv */
// shared constants and types for the power sequencer block
package psq_pkg;
  localparam int CLK_KHZ = 10_000;
  localparam int TW = 24;
  // timing figures and their cycle counts at CLK_KHZ
  localparam int REQ_MIN_MS = 5;
  localparam int REQ_MIN_CYC = REQ_MIN_MS * CLK_KHZ;
  localparam int REQ_MAX_MS = 400;
  localparam int RAMP_CYC = (REQ_MAX_MS - REQ_MIN_MS) * CLK_KHZ;
  localparam int PGOOD_DEL_MS = 5;
  localparam int PGOOD_DEL_CYC = PGOOD_DEL_MS * CLK_KHZ;
  localparam int WARN_US = 150;
  localparam int WARN_CYC = (WARN_US * CLK_KHZ + 999) / 1000;
  localparam int HOLD_MS = 2;
  localparam int HOLD_CYC = HOLD_MS * CLK_KHZ;
  localparam int LOW_MS = 100;
  localparam int LOW_CYC = LOW_MS * CLK_KHZ;
  localparam int COOL_MS = 1000;
  localparam int COOL_CYC = COOL_MS * CLK_KHZ;
  localparam int SB_MAIN_MS = 50;
  localparam int SB_MAIN_CYC = SB_MAIN_MS * CLK_KHZ;
  localparam int SLOW_HALF_MS = 500;
  localparam int SLOW_HALF_CYC = SLOW_HALF_MS * CLK_KHZ;
  localparam int FAST_HALF_MS = 250;
  localparam int FAST_HALF_CYC = FAST_HALF_MS * CLK_KHZ;
  // register map, byte addresses
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam int CTRL_BOOT_BIT = 0;
  localparam logic CTRL_BOOT_RST = 1'b0;
  localparam int STAT_PGOOD_BIT = 0;
  localparam int STAT_MAIN_BIT = 1;
  localparam int STAT_SB_BIT = 2;
  localparam int STAT_FAULT_BIT = 3;
  localparam int STAT_LED_LSB = 4;
  localparam int STAT_SENS_LSB = 8;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  typedef enum logic [2:0] {
    LED_OFF, LED_GREEN_SLOW, LED_AMBER_SOLID, LED_AMBER_SLOW,
    LED_GREEN_FAST, LED_GREEN_SOLID
  } psq_led_e;
  typedef enum logic [2:0] {
    M_OFF, M_SB_WAIT, M_RAMP, M_ON, M_WARN, M_COOL
  } psq_main_e;
  typedef enum logic [1:0] {S_OFF, S_ON, S_COOL} psq_sb_e;

  typedef struct packed {
    logic dc_ok;
    logic sb_fed;
    logic req_n;
    logic main_ok;
    logic sb_ok;
    logic ot_shut;
    logic ov_main;
    logic ov_sb;
    logic ot_warn;
    logic fan_minor;
  } psq_sens_s;
  localparam psq_sens_s SENS_RST = 10'h080;
endpackage : psq_pkg

/* src/psq_timer.sv */
// qualified delay counter, saturates at its limit
`timescale 1ns/1ps
module psq_timer #(
  parameter int W = 24
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // count control
  input wire logic run_i,
  input wire logic [W-1:0] limit_i,
  output logic done_o
);
  logic [W-1:0] cnt_r;
  wire logic at_lim = cnt_r >= limit_i;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i || !run_i) begin
      cnt_r <= '0; // RULE_19
    end else if (!at_lim) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end
  assign done_o = at_lim;
endmodule : psq_timer

/* src/psq_blink.sv */
// status indicator pattern generator
`timescale 1ns/1ps
module psq_blink #(
  parameter int SLOW_HALF = psq_pkg::SLOW_HALF_CYC,
  parameter int FAST_HALF = psq_pkg::FAST_HALF_CYC
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // selected pattern
  input wire psq_pkg::psq_led_e pat_i,
  // indicator drive
  output logic green_o,
  output logic amber_o
);
  import psq_pkg::*;

  function automatic logic [1:0] led_drive(psq_led_e p, logic ph);
    case (p)
      LED_GREEN_SOLID: return 2'b10;
      LED_AMBER_SOLID: return 2'b01;
      LED_GREEN_SLOW, LED_GREEN_FAST: return {ph, 1'b0};
      LED_AMBER_SLOW: return {1'b0, ph};
      default: return 2'b00;
    endcase
  endfunction : led_drive

  psq_led_e pat_r;
  logic [TW-1:0] cnt_r;
  logic ph_r;
  wire logic fast = pat_i == LED_GREEN_FAST;
  wire logic [TW-1:0] half = fast ? TW'(FAST_HALF) : TW'(SLOW_HALF);
  // a new pattern starts lit so a change is visible at once
  wire logic restart = pat_i != pat_r;
  wire logic wrap = cnt_r >= half - TW'(1);
  wire logic [TW-1:0] cnt_nxt = (restart || wrap) ? '0 : cnt_r + 1'b1;
  wire logic ph_nxt = restart ? 1'b1 : (wrap ? !ph_r : ph_r); // RULE_18
  wire logic [1:0] drv_nxt = led_drive(pat_i, ph_nxt);

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      pat_r <= LED_OFF;
      cnt_r <= '0;
      ph_r <= 1'b0;
      green_o <= 1'b0;
      amber_o <= 1'b0;
    end else begin
      pat_r <= pat_i;
      cnt_r <= cnt_nxt;
      ph_r <= ph_nxt;
      green_o <= drv_nxt[1];
      amber_o <= drv_nxt[0];
    end
  end

  blink_restart_a: assert property ( // RULE_18
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (pat_i != pat_r) |=> (cnt_r == '0 && ph_r))
    else $error("blink phase not restarted on pattern change");
endmodule : psq_blink

/* src/psq_top.sv */
// power sequencer, power-good timing and status indicator control
`timescale 1ns/1ps
// What this block does
// RULE_01: request off shows green blinking at 1 Hz, second in priority order after RULE_02
// RULE_02: no input and no fed-back standby turns the indicator fully off
// RULE_03: temperature or rail overvoltage shutdown shows steady amber
// RULE_04: temperature warning or minor fan error blinks amber at 1 Hz
// RULE_05: firmware boot loading blinks green at 2 Hz
// RULE_06: both rails in regulation otherwise shows steady green
// RULE_07: power-good rises 5 to 400 ms after both rails regulate
// RULE_08: power-good falls at least 0.15 ms before main rail drops; a sudden main loss drops both on one edge
// RULE_09: after input loss power-good stays high at least 2 ms
// RULE_10: power-good stays low at least 100 ms before rising again
// RULE_11: main rail regulates 5 to 400 ms after request goes active
// RULE_12: request withdrawn drops power-good within 4 ms
// RULE_13: a rail that leaves regulation stays off about 1 s
// RULE_14: main rail enabled 50 to 1000 ms after standby comes up
// RULE_15: repeated cycling may stretch start-up by up to 1 s
// RULE_16: request low enables main; toggling it clears a latched fault
// RULE_17: power-good requires both standby and main rails in regulation
// RULE_18: blink from divided clock, 50 percent duty, phase restarts on change
// RULE_19: every delay is a counter cleared when its condition goes away
module psq_top #(
  parameter int P_REQ_MIN_CYC = psq_pkg::REQ_MIN_CYC,
  parameter int P_RAMP_CYC = psq_pkg::RAMP_CYC,
  parameter int P_PGOOD_DEL_CYC = psq_pkg::PGOOD_DEL_CYC,
  parameter int P_HOLD_CYC = psq_pkg::HOLD_CYC,
  parameter int P_LOW_CYC = psq_pkg::LOW_CYC,
  parameter int P_COOL_CYC = psq_pkg::COOL_CYC,
  parameter int P_SB_MAIN_CYC = psq_pkg::SB_MAIN_CYC,
  parameter int P_SLOW_HALF = psq_pkg::SLOW_HALF_CYC,
  parameter int P_FAST_HALF = psq_pkg::FAST_HALF_CYC
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // sensed conditions, asynchronous to sys_clk_i
  input wire psq_pkg::psq_sens_s sens_i,
  // avalon-mm slave
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // rail enables and host signal
  output logic main_rail_en_o,
  output logic standby_rail_en_o,
  output logic power_good_o,
  // status indicator
  output logic led_green_o,
  output logic led_amber_o
);
  import psq_pkg::*;

  // input synchroniser and agreement filter
  psq_sens_s s1_r, s2_r, s3_r, f_r;
  wire psq_sens_s f_nxt = psq_sens_s'((s2_r & s3_r) | (f_r & (s2_r | s3_r)));

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      s1_r <= SENS_RST;
      s2_r <= SENS_RST;
      s3_r <= SENS_RST;
      f_r <= SENS_RST;
    end else begin
      s1_r <= sens_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      f_r <= f_nxt;
    end
  end

  wire logic dc_ok = f_r.dc_ok;
  wire logic req_on = !f_r.req_n; // RULE_16
  wire logic rails_ok = f_r.main_ok && f_r.sb_ok;
  wire logic shut_now = f_r.ot_shut || f_r.ov_main || f_r.ov_sb;
  wire logic warn_now = f_r.ot_warn || f_r.fan_minor;

  // state and output registers
  psq_main_e st_r, st_nxt;
  psq_sb_e sb_r, sb_nxt;
  logic main_en_r, sb_en_r, pgood_r, fault_r, req_q_r, sb_ok_q_r, boot_r;
  logic wait_r;
  logic [31:0] rdata_r;

  // withdrawing the request is the toggle that releases a latched fault
  wire logic req_rise = f_r.req_n && !req_q_r;
  wire logic fault_nxt = shut_now || (fault_r && !req_rise); // RULE_16

  // delay timers
  logic st_done, pg_done, low_done, hold_done, sbup_done, cool_done;
  wire logic [TW-1:0] st_lim =
    (st_r == M_SB_WAIT) ? TW'(P_REQ_MIN_CYC) :
    (st_r == M_RAMP) ? TW'(P_RAMP_CYC) :
    (st_r == M_WARN) ? TW'(WARN_CYC) : TW'(P_COOL_CYC);

  psq_timer #(.W(TW)) u_st_tmr (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .run_i(st_nxt == st_r), .limit_i(st_lim), .done_o(st_done));
  psq_timer #(.W(TW)) u_pg_tmr (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .run_i(st_r == M_ON && rails_ok && dc_ok),
    .limit_i(TW'(P_PGOOD_DEL_CYC)), .done_o(pg_done)); // RULE_07
  psq_timer #(.W(TW)) u_low_tmr (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .run_i(!pgood_r),
    .limit_i(TW'(P_LOW_CYC)), .done_o(low_done)); // RULE_10
  psq_timer #(.W(TW)) u_hold_tmr (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .run_i(st_r == M_ON && !dc_ok),
    .limit_i(TW'(P_HOLD_CYC)), .done_o(hold_done)); // RULE_09
  psq_timer #(.W(TW)) u_sbup_tmr (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .run_i(f_r.sb_ok && sb_en_r),
    .limit_i(TW'(P_SB_MAIN_CYC)), .done_o(sbup_done)); // RULE_14
  psq_timer #(.W(TW)) u_cool_tmr (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .run_i(sb_r == S_COOL),
    .limit_i(TW'(P_COOL_CYC)), .done_o(cool_done)); // RULE_13

  // main rail sequencer
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      M_OFF: begin
        if (dc_ok && f_r.sb_ok && req_on && !fault_r) st_nxt = M_SB_WAIT;
      end
      M_SB_WAIT: begin
        // fixed start-up delay, no stretching on repeated cycling
        if (!dc_ok || !f_r.sb_ok || !req_on || fault_r) begin
          st_nxt = M_OFF;
        end else if (st_done && sbup_done) begin
          st_nxt = M_RAMP; // RULE_11 RULE_14 RULE_15
        end
      end
      M_RAMP: begin
        if (shut_now || !req_on || !dc_ok || !f_r.sb_ok) begin
          st_nxt = M_WARN;
        end else if (f_r.main_ok) begin
          st_nxt = M_ON;
        end else if (st_done) begin
          st_nxt = M_COOL; // RULE_11
        end
      end
      M_ON: begin
        // a sudden main loss cannot be warned of; power-good drops with it
        if (!f_r.main_ok) begin
          st_nxt = M_COOL; // RULE_13
        end else if (shut_now || !req_on || !f_r.sb_ok) begin
          st_nxt = M_WARN; // RULE_08 RULE_12
        end else if (!dc_ok && hold_done) begin
          st_nxt = M_WARN; // RULE_09
        end
      end
      M_WARN: begin
        if (st_done || !f_r.main_ok) st_nxt = M_OFF; // RULE_08
      end
      M_COOL: begin
        if (st_done) st_nxt = M_OFF; // RULE_13
      end
      default: st_nxt = M_OFF;
    endcase
  end

  // standby rail: once up it stays on until it leaves regulation
  always_comb begin
    sb_nxt = sb_r;
    case (sb_r)
      S_OFF: begin
        if (dc_ok) sb_nxt = S_ON;
      end
      S_ON: begin
        if (sb_ok_q_r && !f_r.sb_ok) sb_nxt = S_COOL; // RULE_13
      end
      S_COOL: begin
        if (cool_done) sb_nxt = S_OFF; // RULE_13
      end
      default: sb_nxt = S_OFF;
    endcase
  end

  wire logic main_en_nxt =
    st_nxt == M_RAMP || st_nxt == M_ON || st_nxt == M_WARN;
  wire logic pg_keep = st_r == M_ON && st_nxt == M_ON && rails_ok; // RULE_17
  wire logic pg_nxt =
    pg_keep && (pgood_r || (pg_done && low_done && dc_ok)); // RULE_07 RULE_10

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      st_r <= M_OFF;
      sb_r <= S_OFF;
      main_en_r <= 1'b0;
      sb_en_r <= 1'b0;
      pgood_r <= 1'b0;
      fault_r <= 1'b0;
      req_q_r <= 1'b1;
      sb_ok_q_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      sb_r <= sb_nxt;
      main_en_r <= main_en_nxt;
      sb_en_r <= sb_nxt == S_ON;
      pgood_r <= pg_nxt;
      fault_r <= fault_nxt;
      req_q_r <= f_r.req_n;
      sb_ok_q_r <= f_r.sb_ok;
    end
  end

  // indicator precedence
  wire psq_led_e led_pat =
    (!dc_ok && !f_r.sb_fed) ? LED_OFF : // RULE_02
    !req_on ? LED_GREEN_SLOW : // RULE_01
    (shut_now || fault_r) ? LED_AMBER_SOLID : // RULE_03
    warn_now ? LED_AMBER_SLOW : // RULE_04
    boot_r ? LED_GREEN_FAST : // RULE_05
    (rails_ok && main_en_r) ? LED_GREEN_SOLID : // RULE_06
    LED_GREEN_SLOW;

  psq_blink #(.SLOW_HALF(P_SLOW_HALF), .FAST_HALF(P_FAST_HALF)) u_blink (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .pat_i(led_pat),
    .green_o(led_green_o), .amber_o(led_amber_o));

  // register slave: one wait cycle, answer on the following edge
  wire logic bus_req = avs_read_i || avs_write_i;
  wire logic bus_take = bus_req && !wait_r;
  wire logic hit_ctrl = avs_address_i == REG_CTRL;
  wire logic hit_stat = avs_address_i == REG_STAT;
  wire logic wait_nxt = !(bus_req && wait_r);
  wire logic boot_wr = bus_take && avs_write_i && hit_ctrl &&
    avs_byteenable_i[0];
  logic [31:0] ctrl_word, stat_word;

  always_comb begin
    ctrl_word = RD_ZERO;
    ctrl_word[CTRL_BOOT_BIT] = boot_r;
    stat_word = RD_ZERO;
    stat_word[STAT_PGOOD_BIT] = pgood_r;
    stat_word[STAT_MAIN_BIT] = main_en_r;
    stat_word[STAT_SB_BIT] = sb_en_r;
    stat_word[STAT_FAULT_BIT] = fault_r;
    stat_word[STAT_LED_LSB +: 3] = led_pat;
    stat_word[STAT_SENS_LSB +: 10] = f_r;
  end

  wire logic [31:0] rd_sel = hit_ctrl ? ctrl_word :
    hit_stat ? stat_word : RD_ZERO;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      wait_r <= 1'b1;
      rdata_r <= RD_ZERO;
      boot_r <= CTRL_BOOT_RST;
    end else begin
      wait_r <= wait_nxt;
      if (bus_req && wait_r && avs_read_i) rdata_r <= rd_sel;
      if (boot_wr) boot_r <= avs_writedata_i[CTRL_BOOT_BIT];
    end
  end

  assign avs_waitrequest_o = wait_r;
  assign avs_readdata_o = rdata_r;
  assign main_rail_en_o = main_en_r;
  assign standby_rail_en_o = sb_en_r;
  assign power_good_o = pgood_r;

  // checking helpers
  int ok_cnt_r, low_cnt_r, dcl_cnt_r;
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      ok_cnt_r <= 0;
      low_cnt_r <= 0;
      dcl_cnt_r <= 0;
    end else begin
      ok_cnt_r <= (st_r == M_ON && rails_ok && dc_ok) ? ok_cnt_r + 1 : 0;
      low_cnt_r <= !pgood_r ? low_cnt_r + 1 : 0;
      dcl_cnt_r <= (st_r == M_ON && !dc_ok) ? dcl_cnt_r + 1 : 0;
    end
  end

  pgood_delay_a: assert property ( // RULE_07
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    $rose(pgood_r) |-> ok_cnt_r >= P_PGOOD_DEL_CYC)
    else $error("power-good rose before the rails settled");
  low_hold_a: assert property ( // RULE_10
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    $rose(pgood_r) |-> low_cnt_r >= P_LOW_CYC)
    else $error("power-good low time too short");
  warn_lead_a: assert property ( // RULE_08
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    ($fell(main_en_r) && $past(st_r) == M_WARN && $past(f_r.main_ok))
    |-> (!pgood_r && low_cnt_r >= WARN_CYC))
    else $error("main disabled without power-good warning");
  req_drop_a: assert property ( // RULE_12
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    $rose(f_r.req_n) |=> !pgood_r)
    else $error("power-good kept after request withdrawn");
  hold_dc_a: assert property ( // RULE_09
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (pgood_r && !dc_ok && dcl_cnt_r < P_HOLD_CYC && req_on && rails_ok &&
     !shut_now) |=> pgood_r)
    else $error("power-good dropped inside hold time");
  both_ok_a: assert property ( // RULE_17
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    pgood_r |-> $past(rails_ok))
    else $error("power-good high with a rail out of regulation");
  led_off_a: assert property ( // RULE_02
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (!dc_ok && !f_r.sb_fed) |=> (!led_green_o && !led_amber_o))
    else $error("indicator lit with no supply");
  amber_solid_a: assert property ( // RULE_03
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (dc_ok && req_on && shut_now) |=> (led_amber_o && !led_green_o))
    else $error("shutdown not shown as steady amber");
  green_slow_a: assert property ( // RULE_01
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (dc_ok && !req_on) |-> led_pat == LED_GREEN_SLOW ##1 !led_amber_o)
    else $error("request off not shown as slow green");
  amber_warn_a: assert property ( // RULE_04
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (dc_ok && req_on && !shut_now && !fault_r && warn_now)
    |=> !led_green_o)
    else $error("warning shows green");
endmodule : psq_top

/* dv/psq_host_model.sv */
// host controller model: drives the main on request, watches power good
`timescale 1ns/1ps
module psq_host_model (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // bench command and device status
  input wire logic on_cmd_i,
  input wire logic power_good_i,
  // request to the device, active low
  output logic main_on_request_n_o,
  output logic [15:0] pg_rise_cnt_o
);
  logic pg_d_r;
  // released to the pull-up level in reset, so the main rail stays off
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      main_on_request_n_o <= 1'b1;
      pg_d_r <= 1'b0;
      pg_rise_cnt_o <= 16'h0000;
    end else begin
      main_on_request_n_o <= !on_cmd_i;
      pg_d_r <= power_good_i;
      if (power_good_i && !pg_d_r) begin
        pg_rise_cnt_o <= pg_rise_cnt_o + 16'h0001;
      end
    end
  end
endmodule : psq_host_model

/* dv/psu_status_led_and_power_good_sequencer_tb.sv */
// self-checking bench for the power sequencer top
`timescale 1ns/1ps
module psu_status_led_and_power_good_sequencer_tb;
  import psq_pkg::*;
  localparam int T_REQ = 20;
  localparam int T_PGD = 20;
  localparam int T_HOLD = 10;
  localparam int T_LOW = 100;
  localparam int T_COOL = 300;
  localparam int T_SB = 40;
  localparam int SLOW = 8;
  localparam int FAST = 4;
  localparam int LIMIT = 40000;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic on_cmd = 1'b0;
  logic req_n;
  psq_sens_s sens_d = SENS_RST;
  psq_sens_s sens_w;
  logic [3:0] addr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] be = 4'h0;
  logic [31:0] rdata;
  logic wait_rq, main_en, sb_en, pg, led_g, led_a;
  logic [15:0] pg_rises;
  logic [31:0] lfsr = 32'h0000_7a9f;
  int cyc = 0, miscompares = 0, cmp_count = 0, pg_fall = 0, pg_exp = 0;
  int m_dc = 0, m_fed = 0, m_req_n = 1, m_shut = 0, m_fault = 0;
  int m_warn = 0, m_boot = 0, m_on = 0;

  always #50 sys_clk = ~sys_clk;
  // the request line has a pull-up, so a released line reads high
  always_comb begin
    sens_w = sens_d;
    sens_w.req_n = (req_n === 1'b0) ? 1'b0 : 1'b1;
  end
  always @(negedge pg) pg_fall = cyc;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc > LIMIT) begin
      miscompares++;
      stop_test();
    end
  end

  psq_top #(.P_REQ_MIN_CYC(T_REQ), .P_RAMP_CYC(200), .P_PGOOD_DEL_CYC(T_PGD),
    .P_HOLD_CYC(T_HOLD), .P_LOW_CYC(T_LOW), .P_COOL_CYC(T_COOL),
    .P_SB_MAIN_CYC(T_SB), .P_SLOW_HALF(SLOW), .P_FAST_HALF(FAST)) uut (
    .sys_clk_i(sys_clk), .rst_n_i(rst_n), .sens_i(sens_w),
    .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdata), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wait_rq),
    .main_rail_en_o(main_en), .standby_rail_en_o(sb_en),
    .power_good_o(pg), .led_green_o(led_g), .led_amber_o(led_a));

  psq_host_model host (.sys_clk_i(sys_clk), .rst_n_i(rst_n),
    .on_cmd_i(on_cmd), .power_good_i(pg), .main_on_request_n_o(req_n),
    .pg_rise_cnt_o(pg_rises));

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  task automatic chk_rng(input string nm, input int n, input int lo,
                         input int hi);
    cmp_count++;
    if (n < lo || n > hi) begin
      miscompares++;
      $display("BAD %s expected %0d..%0d seen %0d", nm, lo, hi, n);
    end
  endtask : chk_rng

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  // indicator pattern from the precedence list, first match wins
  function automatic int led_model();
    if (!m_dc && !m_fed) return 0;
    if (m_req_n) return 1;
    if (m_shut || m_fault) return 2;
    if (m_warn) return 3;
    if (m_boot) return 4;
    if (m_on) return 5;
    return 1;
  endfunction : led_model

  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d, input logic [3:0] b,
                     output logic [31:0] q);
    int n;
    @(posedge sys_clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    be <= b;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wait_rq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    chk_rng("bus answer", n, 1, 49);
  endtask : bus

  task automatic led_chk();
    logic [31:0] q;
    repeat (8) @(posedge sys_clk);
    bus(1'b0, REG_STAT, 32'h0000_0000, 4'hf, q);
    chk("led pattern", 32'(led_model()), {29'h0000_0000, q[6:4]});
  endtask : led_chk

  task automatic wait_lvl(input int s, input logic v, input int lo,
                          input int hi, input string nm);
    int n;
    n = 0;
    while (((s == 0) ? main_en : (s == 1) ? pg : sb_en) !== v &&
           n <= hi) begin
      @(posedge sys_clk);
      n++;
    end
    chk_rng(nm, n, lo, hi);
  endtask : wait_lvl

  // measures one whole half period, after the first edge seen
  task automatic half(input logic amber, input int e);
    logic v;
    int n;
    for (int k = 0; k < 2; k++) begin
      v = amber ? led_a : led_g;
      n = 0;
      while ((amber ? led_a : led_g) === v && n < 100) begin
        @(posedge sys_clk);
        n++;
      end
    end
    chk_rng("blink half", n, e, e);
  endtask : half

  task automatic pwr_on(input int lo);
    @(posedge sys_clk);
    on_cmd <= 1'b1;
    m_req_n = 0;
    wait_lvl(0, 1'b1, lo, T_SB + 12, "main enable");
    sens_d.main_ok <= 1'b1;
    wait_lvl(1, 1'b1, T_PGD, T_PGD + 12, "pgood rise");
    chk_rng("pgood low time", cyc - pg_fall, T_LOW, LIMIT);
    pg_exp++;
    m_on = 1;
  endtask : pwr_on

  task automatic drop_main(input string nm);
    wait_lvl(0, 1'b0, WARN_CYC, WARN_CYC + 4, nm);
    sens_d.main_ok <= 1'b0;
    m_on = 0;
  endtask : drop_main

  initial begin
    logic [31:0] q;
    repeat (8) @(posedge sys_clk);
    chk("reset outputs", 32'h0000_0020,
        {26'h000_0000, wait_rq, main_en, sb_en, pg, led_g, led_a});
    rst_n <= 1'b1;
    bus(1'b0, REG_CTRL, 32'h0000_0000, 4'hf, q);
    chk("ctrl reset", 32'h0000_0000, q);
    bus(1'b1, REG_CTRL, 32'h0000_0001, 4'hf, q);
    bus(1'b1, REG_CTRL, 32'h0000_0000, 4'he, q);
    bus(1'b1, REG_STAT, 32'hffff_ffff, 4'hf, q);
    bus(1'b0, REG_CTRL, 32'h0000_0000, 4'hf, q);
    chk("ctrl boot", 32'h0000_0001, q);
    bus(1'b0, 4'h8, 32'h0000_0000, 4'hf, q);
    chk("unmapped read", 32'h0000_0000, q);
    bus(1'b1, REG_CTRL, 32'h0000_0000, 4'hf, q);
    sens_d.dc_ok <= 1'b1;
    m_dc = 1;
    led_chk();
    chk("standby enable", 32'h0000_0001, {31'h0000_0000, sb_en});
    half(1'b0, SLOW);
    sens_d.sb_ok <= 1'b1;
    pwr_on(T_SB - 2);
    led_chk();
    for (int i = 0; i < 6; i++) begin
      lfsr = lfsr_next(lfsr);
      sens_d.ot_warn <= lfsr[0];
      sens_d.fan_minor <= lfsr[1];
      m_warn = lfsr[0] | lfsr[1];
      bus(1'b1, REG_CTRL, {31'h0000_0000, lfsr[2]}, 4'hf, q);
      m_boot = lfsr[2];
      led_chk();
    end
    sens_d.ot_warn <= 1'b1;
    sens_d.fan_minor <= 1'b0;
    bus(1'b1, REG_CTRL, 32'h0000_0000, 4'hf, q);
    half(1'b1, SLOW);
    sens_d.ot_warn <= 1'b0;
    bus(1'b1, REG_CTRL, 32'h0000_0001, 4'hf, q);
    half(1'b0, FAST);
    bus(1'b1, REG_CTRL, 32'h0000_0000, 4'hf, q);
    m_warn = 0;
    m_boot = 0;
    @(posedge sys_clk);
    on_cmd <= 1'b0;
    m_req_n = 1;
    wait_lvl(1, 1'b0, 1, 10, "pgood drop");
    drop_main("off warning");
    led_chk();
    // each shutdown cause, then clear only by toggling the request
    for (int i = 0; i < 3; i++) begin
      pwr_on(T_REQ);
      sens_d <= sens_d | (10'h010 >> i);
      m_shut = 1;
      m_fault = 1;
      wait_lvl(1, 1'b0, 1, 10, "shutdown drop");
      drop_main("shutdown warning");
      led_chk();
      chk("amber solid", 32'h0000_0001, {30'h0000_0000, led_g, led_a});
      sens_d <= sens_d & 10'h3e3;
      m_shut = 0;
      repeat (100) @(posedge sys_clk);
      led_chk();
      chk("latched off", 32'h0000_0000, {31'h0000_0000, main_en});
      on_cmd <= 1'b0;
      m_req_n = 1;
      m_fault = 0;
      repeat (10) @(posedge sys_clk);
    end
    pwr_on(T_REQ);
    sens_d.main_ok <= 1'b0;
    wait_lvl(0, 1'b0, 1, 10, "main loss");
    chk("pgood on main loss", 32'h0000_0000, {31'h0000_0000, pg});
    wait_lvl(0, 1'b1, T_COOL, T_COOL + T_REQ + 20, "main off time");
    sens_d.main_ok <= 1'b1;
    wait_lvl(1, 1'b1, T_PGD, T_PGD + 12, "pgood again");
    pg_exp++;
    sens_d.dc_ok <= 1'b0;
    sens_d.sb_fed <= 1'b1;
    m_dc = 0;
    m_fed = 1;
    wait_lvl(1, 1'b0, T_HOLD, T_HOLD + 10, "dc hold");
    drop_main("dc warning");
    led_chk();
    sens_d.sb_fed <= 1'b0;
    m_fed = 0;
    led_chk();
    chk("led dark", 32'h0000_0000, {30'h0000_0000, led_g, led_a});
    chk("pgood rises", 32'(pg_exp), {16'h0000, pg_rises});
    // standby loss: rail held off for the cool-down, back once input is up
    sens_d.dc_ok <= 1'b1;
    sens_d.sb_ok <= 1'b0;
    wait_lvl(2, 1'b0, 1, 10, "standby loss");
    sens_d.sb_ok <= 1'b1;
    wait_lvl(2, 1'b1, T_COOL, T_COOL + 10, "standby off time");
    stop_test();
  end
endmodule : psu_status_led_and_power_good_sequencer_tb
